/* File: core/monitor_serial.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module monitor_serial
  import monitor_serial_pkg::*;
(
  input  wire logic        clk,        // System clock, 25 MHz
  input  wire logic        rst,        // Synchronous reset, active high
  input  wire logic [7:0]  addr,       // Register byte address
  input  wire logic [31:0] wdata,      // Write data
  input  wire logic        wr,         // Write strobe
  input  wire logic        rd,         // Read strobe
  output logic      [31:0] rdata,      // Read data, cycle after rd
  input  wire logic        pin_in,     // Single-wire pin level
  output logic             pin_out,    // Single-wire pin output value
  output logic             pin_oe_n,   // Pin output enable, low drives
  input  wire logic        alt_out,    // General UART/GPIO output value
  input  wire logic        alt_oe_n,   // General UART/GPIO enable, low drives
  output logic             monitor_on  // Monitor owns the pin
);

  ctrl_type    ctrl_q, ctrl_d;
  state_type   state_q, state_d;
  logic [15:0] reload_q, baud_cnt_q;
  logic [3:0]  idx_q;
  logic [10:0] tx_frame_q;
  logic [8:0]  rx_shift_q, rx_data_q;
  logic        rx_valid_q, rx_err_q, pin_prev_q;
  logic [31:0] rdata_q;
  logic        pin_out_q, pin_oe_n_q, monitor_on_q;

  // Register decode
  wire wr_ctrl   = wr && (addr == CTRL_OFS);
  wire wr_reload = wr && (addr == RELOAD_OFS);
  wire wr_tx     = wr && (addr == TXDATA_OFS);
  wire rd_rx     = rd && (addr == RXDATA_OFS);

  // State decode
  wire st_idle  = (state_q == S_IDLE);
  wire st_tx    = (state_q == S_TX);
  wire st_start = (state_q == S_RX_START);
  wire st_data  = (state_q == S_RX_DATA);
  wire st_stop  = (state_q == S_RX_STOP);
  wire st_baud  = (state_q == S_BAUD);
  wire st_brk   = (state_q == S_BREAK);
  wire rx_busy  = st_start | st_data | st_stop | st_baud;

  // Bit timing from the reload value
  wire [15:0] eff_reload = ctrl_q.enable ? {{(16-LIMIT_BITS){1'b0}}, reload_q[LIMIT_BITS-1:0]}
                                         : reload_q;
  wire [15:0] bit_raw    = eff_reload >> BIT_SHIFT;
  wire [15:0] half_raw   = eff_reload >> HALF_SHIFT;
  wire [15:0] bit_len    = (bit_raw == 16'h0000) ? 16'h0001 : bit_raw;
  wire [15:0] half_len   = (half_raw == 16'h0000) ? 16'h0001 : half_raw;

  // Frame and line decode
  wire [3:0] nbits      = ctrl_q.nine ? WIDE_BITS : NARROW_BITS;
  wire       last_tx    = (idx_q == nbits + 4'h1);
  wire       last_rx    = (idx_q == nbits - 4'h1);
  wire       cur_tx_bit = tx_frame_q[idx_q];
  wire       fall       = pin_prev_q && !pin_in;
  wire       expire;
  wire       tx_go      = st_idle && wr_tx && ctrl_q.enable && !ctrl_q.autobaud && !fall;
  wire       collision  = st_tx && expire && cur_tx_bit && !pin_in;
  wire       frame_err  = st_stop && expire && !pin_in;
  wire       rx_done    = st_stop && expire && pin_in;
  wire       baud_done  = st_baud && pin_in;
  wire       drive_low  = st_brk | (st_tx & ~cur_tx_bit);

  // Next state of the serial engine
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (tx_go) begin
          state_d = S_TX;
        end else if (fall && ctrl_q.autobaud) begin
          state_d = S_BAUD;
        end else if (fall) begin
          state_d = S_RX_START;
        end
      end
      S_TX: begin
        if (collision) begin
          state_d = S_BREAK;
        end else if (expire && last_tx) begin
          state_d = S_IDLE;
        end
      end
      S_RX_START: begin
        if (expire) begin
          state_d = pin_in ? S_IDLE : S_RX_DATA;
        end
      end
      S_RX_DATA: begin
        if (expire && last_rx) begin
          state_d = S_RX_STOP;
        end
      end
      S_RX_STOP: begin
        if (expire) begin
          state_d = pin_in ? S_IDLE : S_BREAK;
        end
      end
      S_BAUD: begin
        if (pin_in) begin
          state_d = S_IDLE;
        end
      end
      S_BREAK: begin
        if (expire) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (!ctrl_q.enable) begin
      state_d = S_IDLE;
    end
  end

  // Timer reload on entry to a timed state and on each bit boundary
  wire enter_timed = (state_d != state_q) && (state_d != S_IDLE) && (state_d != S_BAUD);
  wire next_bit    = expire && ((st_tx && !last_tx && !collision) || (st_data && !last_rx));
  wire timer_load  = enter_timed || next_bit;
  wire [15:0] timer_val = (state_d == S_RX_START) ? half_len :
                          (state_d == S_BREAK)    ? BREAK_LOAD :
                                                    bit_len;

  bit_timer #(
    .W (16)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .load   (timer_load),
    .val    (timer_val),
    .expire (expire)
  );

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.lock = ctrl_q.lock | wdata[LOCK_BIT];
      ctrl_d.nine = wdata[NINE_BIT];
      if (wdata[EN_BIT] || !ctrl_q.lock) begin
        ctrl_d.enable = wdata[EN_BIT];
      end
      if (wdata[ABORT_BIT]) begin
        ctrl_d.abort = 1'b0;
      end
      if (wdata[AUTOBAUD_BIT]) begin
        ctrl_d.autobaud = 1'b1;
      end
    end
    if (baud_done) begin
      ctrl_d.autobaud = 1'b0;
    end
    if (collision || frame_err) begin
      ctrl_d.abort = 1'b1;
    end
  end

  // Control and reload registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q   <= CTRL_RST;
      reload_q <= RELOAD_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (baud_done) begin
        reload_q <= baud_cnt_q;
      end else if (wr_reload) begin
        reload_q <= wdata[15:0];
      end
    end
  end

  // Engine state, bit index and baud measurement
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= S_IDLE;
      idx_q      <= 4'h0;
      baud_cnt_q <= 16'h0000;
      pin_prev_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      pin_prev_q <= pin_in;
      if (state_d != state_q) begin
        idx_q <= 4'h0;
      end else if (next_bit) begin
        idx_q <= idx_q + 4'h1;
      end
      if (st_idle && fall) begin
        baud_cnt_q <= 16'h0001;
      end else if (st_baud && !pin_in && baud_cnt_q != 16'hffff) begin
        baud_cnt_q <= baud_cnt_q + 16'h0001;
      end
    end
  end

  // Transmit frame and receive shift register
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_frame_q <= 11'h7ff;
      rx_shift_q <= 9'h000;
    end else begin
      if (tx_go) begin
        tx_frame_q <= ctrl_q.nine ? {1'b1, wdata[8:0], 1'b0}
                                  : {2'b11, wdata[7:0], 1'b0};
      end
      if (state_d == S_RX_DATA && st_start) begin
        rx_shift_q <= 9'h000;
      end else if (st_data && expire) begin
        rx_shift_q[idx_q] <= pin_in;
      end
    end
  end

  // Received character and its flags, set wins over read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_q  <= 9'h000;
      rx_valid_q <= 1'b0;
      rx_err_q   <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data_q <= rx_shift_q;
      end
      rx_valid_q <= rx_done | (rx_valid_q & ~rd_rx);
      rx_err_q   <= frame_err | (rx_err_q & ~rd_rx);
    end
  end

  // Read data mux, zero for unmapped offsets
  wire [31:0] rd_mux =
    (addr == CTRL_OFS)   ? {27'h0, ctrl_q} :
    (addr == RELOAD_OFS) ? {16'h0, reload_q} :
    (addr == RXDATA_OFS) ? {14'h0, rx_err_q, rx_valid_q, 7'h0, rx_data_q} :
    (addr == STATUS_OFS) ? {28'h0, ctrl_q.autobaud, st_brk, rx_busy, st_tx} :
                           32'h0;

  // Output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q      <= 32'h0;
      pin_out_q    <= 1'b0;
      pin_oe_n_q   <= 1'b1;
      monitor_on_q <= 1'b1;
    end else begin
      rdata_q      <= rd ? rd_mux : 32'h0;
      pin_out_q    <= ctrl_q.enable ? 1'b0 : alt_out;
      pin_oe_n_q   <= ctrl_q.enable ? ~drive_low : alt_oe_n;
      monitor_on_q <= ctrl_q.enable;
    end
  end

  assign rdata      = rdata_q;
  assign pin_out    = pin_out_q;
  assign pin_oe_n   = pin_oe_n_q;
  assign monitor_on = monitor_on_q;

  // Checks
  AST_RESET_ENABLE: assert property (@(posedge clk) rst |=> ctrl_q.enable)
    else $error("monitor not enabled after reset");
  AST_DISABLE: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl && !wdata[EN_BIT] && !ctrl_q.lock |=> !ctrl_q.enable ##1 !monitor_on)
    else $error("enable clear did not disable monitor");
  AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (rst)
    ctrl_q.lock && ctrl_q.enable |=> ctrl_q.enable)
    else $error("locked monitor was disabled");
  AST_HANDOVER: assert property (@(posedge clk) disable iff (rst)
    !ctrl_q.enable |=> pin_oe_n == $past(alt_oe_n) && pin_out == $past(alt_out))
    else $error("pin not handed to general use");
  AST_HALF_DUPLEX: assert property (@(posedge clk) disable iff (rst)
    rx_busy && ctrl_q.enable |=> pin_oe_n)
    else $error("transmit while receiving");
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
    ctrl_q.enable |=> !pin_out)
    else $error("pin driven high by monitor");
  AST_START_LOW: assert property (@(posedge clk) disable iff (rst)
    st_tx && idx_q == 4'h0 && ctrl_q.enable |=> !pin_oe_n)
    else $error("start bit not low");
  AST_STOP_HIGH: assert property (@(posedge clk) disable iff (rst)
    st_tx && last_tx && ctrl_q.enable |=> pin_oe_n)
    else $error("stop bit not released");
  AST_FALSE_START: assert property (@(posedge clk) disable iff (rst)
    st_start && expire && pin_in |=> st_idle)
    else $error("false start not discarded");
  AST_RESUME: assert property (@(posedge clk) disable iff (rst)
    rx_done |=> st_idle && rx_valid_q)
    else $error("receiver did not resume after stop sample");
  AST_BREAK: assert property (@(posedge clk) disable iff (rst)
    (collision || frame_err) && ctrl_q.enable |=> st_brk && ctrl_q.abort ##1 !pin_oe_n)
    else $error("error did not start break");
  AST_BAUD_LOAD: assert property (@(posedge clk) disable iff (rst)
    baud_done && !wr_reload |=> reload_q == $past(baud_cnt_q) && !ctrl_q.autobaud)
    else $error("measured count not loaded");
  AST_LIMIT: assert property (@(posedge clk) disable iff (rst)
    ctrl_q.enable |-> eff_reload[15:LIMIT_BITS] == '0)
    else $error("reload not limited while enabled");

endmodule // monitor_serial

/* File: inc/monitor_serial_pkg.sv */
// Behaviour
// - Reset always brings the monitor up enabled on the single-wire pin.
// - Software clearing the monitor enable bit disables the monitor.
// - While the lock bit is set, clearing the enable bit is ignored.
// - The pin goes to general UART or GPIO use only while monitor is disabled.
// - Half duplex: never transmit while a character is being received.
// - Pin is open-drain: pulled low only, never driven high.
// - Frame is start bit, 8 or 9 data bits LSB first, one stop bit.
// - Every bit lasts one equal period taken from the bit clock generator.
// - Transmit a low start bit for one bit time, then each data bit.
// - After the last data bit send a high stop bit for one bit time.
// - Half a bit after a falling edge sample start; high means false start.
// - Sample each data bit at mid-bit, one full bit time apart.
// - Sample stop one bit after last data; low is a framing error.
// - Resume edge search right after the mid-stop sample.
// - Reload register loads from baud measurement and from software writes.
// - Reload value counts system clocks spanning eight bit times.
// - 16-bit reload counter, limited to 12 bits while monitor is enabled.
// - Baud measure times start falling edge to data bit seven rising edge.
// - Collision or framing error: break for 4096 clocks and set abort flag.
package monitor_serial_pkg;

  // Register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RELOAD_OFS = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Control register field positions
  localparam int EN_BIT       = 0;
  localparam int LOCK_BIT     = 1;
  localparam int ABORT_BIT    = 2;
  localparam int NINE_BIT     = 3;
  localparam int AUTOBAUD_BIT = 4;

  // Receive data register flag positions
  localparam int RX_VALID_BIT = 16;
  localparam int RX_ERR_BIT   = 17;

  // Bit clock and frame constants
  localparam logic [15:0] RELOAD_RST  = 16'h0100;
  localparam int          LIMIT_BITS  = 12;
  localparam int          BIT_SHIFT   = 3;
  localparam int          HALF_SHIFT  = 4;
  localparam int          BREAK_CLKS  = 4096;
  localparam logic [15:0] BREAK_LOAD  = 16'(BREAK_CLKS);
  localparam logic [3:0]  NARROW_BITS = 4'h8;
  localparam logic [3:0]  WIDE_BITS   = 4'h9;

  // Control register layout, low bit is the enable
  typedef struct packed {
    logic autobaud;
    logic nine;
    logic abort;
    logic lock;
    logic enable;
  } ctrl_type;

  localparam ctrl_type CTRL_RST = '{autobaud: 1'b1, nine: 1'b0, abort: 1'b0, lock: 1'b0, enable: 1'b1};

  // Serial engine states
  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_TX       = 7'h02,
    S_RX_START = 7'h04,
    S_RX_DATA  = 7'h08,
    S_RX_STOP  = 7'h10,
    S_BAUD     = 7'h20,
    S_BREAK    = 7'h40
  } state_type;

endpackage

/* File: core/bit_timer.sv */
`timescale 1ns/1ps
module bit_timer
  import monitor_serial_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,     // System clock
  input  wire logic         rst,     // Synchronous reset
  input  wire logic         load,    // Start a new interval
  input  wire logic [W-1:0] val,     // Interval length in clocks
  output logic              expire   // Last clock of the interval
);

  logic [W-1:0] cnt_q;

  // Down counter, parks at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign expire = (cnt_q == W'(1));

  // One interval is exactly val clocks long: full load, then one step per clock
  AST_TIMER_SPAN: assert property (@(posedge clk) disable iff (rst)
    load |=> cnt_q == $past(val))
    else $error("timer interval length wrong");
  AST_TIMER_STEP: assert property (@(posedge clk) disable iff (rst)
    !load && cnt_q != '0 |=> cnt_q == $past(cnt_q) - W'(1))
    else $error("timer did not count down by one");

endmodule // bit_timer

/* File: sim/host_port.sv */
`timescale 1ns/1ps
module host_port (
  input  wire logic        clk,       // System clock
  input  wire logic        line,      // Resolved pin level
  input  wire logic        listen,    // Receiver armed
  input  wire logic [15:0] bit_clks,  // Clocks per bit
  output logic             drive_low, // Pulls the line low
  output logic             got,       // Character received pulse
  output logic [7:0]       got_data   // Received character
);
  logic busy_rx;
  logic sending;
  logic last;
  logic [7:0] d;

  initial begin
    drive_low = 1'b0;
    got = 1'b0;
    got_data = 8'h00;
    busy_rx = 1'b0;
    sending = 1'b0;
  end

  // Sends start, n data bits LSB first and a chosen stop level
  task automatic send(input logic [8:0] v, input int n, input logic stop);
    logic b;
    wait (!busy_rx);
    sending = 1'b1;
    for (int i = 0; i < n + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i <= n) ? v[i-1] : stop;
      @(posedge clk);
      drive_low <= ~b;
      repeat (bit_clks - 1) @(posedge clk);
    end
    @(posedge clk);
    drive_low <= 1'b0;
    sending = 1'b0;
  endtask

  // Short low pulse that must not count as a start bit
  task automatic glitch(input int n);
    @(posedge clk);
    drive_low <= 1'b1;
    repeat (n) @(posedge clk);
    drive_low <= 1'b0;
  endtask

  // Receiver samples mid-bit and drops frames with a low stop bit
  initial begin
    last = 1'b1;
    forever begin
      @(posedge clk);
      if (last === 1'b1 && line === 1'b0 && !sending && listen === 1'b1) begin
        busy_rx = 1'b1;
        repeat (bit_clks / 2) @(posedge clk);
        if (line === 1'b0) begin
          for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge clk);
            d[i] = line;
          end
          repeat (bit_clks) @(posedge clk);
          if (line === 1'b1) begin
            got_data <= d;
            got <= 1'b1;
            @(posedge clk);
            got <= 1'b0;
          end
        end
        busy_rx = 1'b0;
      end
      last = line;
    end
  end
endmodule // host_port

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import monitor_serial_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h24bf;
  logic pin_out, pin_oe_n, monitor_on, host_low, got, pin;
  logic alt_out = 1'b0, alt_oe_n = 1'b1;
  logic [15:0] bclk = 16'h0010;
  logic [7:0] got_data, v;
  logic [63:0] exp_rd[$];
  logic [7:0] exp_rx[$];
  int error_cnt = 0, comparisons = 0, cycles = 0, n;

  always #20 clk = ~clk;
  // Open-drain wire with pull-up
  assign pin = (pin_oe_n ? 1'b1 : pin_out) & ~host_low;

  monitor_serial DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_oe_n(alt_oe_n),
    .monitor_on(monitor_on));
  host_port host (.clk(clk), .line(pin), .listen(monitor_on), .bit_clks(bclk), .drive_low(host_low),
    .got(got), .got_data(got_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read with expected value and mask noted for the watcher
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_rd.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Watcher: compares read data and host characters, guards the run time
  always @(posedge clk) begin
    rd_q <= rd;
    cycles++;
    if (rd_q) begin
      if (exp_rd.size() == 0) chk(1'b0, "unexpected read");
      else chk((rdata & exp_rd[0][63:32]) === exp_rd[0][31:0], "read data");
      if (exp_rd.size() != 0) void'(exp_rd.pop_front());
    end
    if (got === 1'b1) begin
      if (exp_rx.size() == 0) chk(1'b0, "unexpected character");
      else chk(got_data === exp_rx.pop_front(), "transmitted character");
    end
    if (monitor_on === 1'b1 && pin_oe_n === 1'b0 && pin_out !== 1'b0) chk(1'b0, "pin driven high");
    if (cycles > 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset state and an unmapped read
    rd_reg(CTRL_OFS, 32'h11, 32'hffffffff);
    rd_reg(RELOAD_OFS, {16'h0, RELOAD_RST}, 32'hffff);
    rd_reg(8'h14, 32'h0, 32'hffffffff);
    rd_reg(STATUS_OFS, 32'h8, 32'hf);
    chk(monitor_on === 1'b1, "monitor off after reset");
    $display("test reset done");
    // Measurement character, eight low bit times of 16 clocks
    host.send(9'h080, 8, 1'b1);
    repeat (4) @(posedge clk);
    rd_reg(RELOAD_OFS, 32'h80, 32'hffff);
    rd_reg(CTRL_OFS, 32'h01, 32'h1f);
    $display("test autobaud done");
    // Upper reload bits ignored while the monitor is on, so 8 clocks per bit
    wr_reg(RELOAD_OFS, 32'hf040);
    bclk = 16'h0008;
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      exp_rx.push_back(seed[7:0]);
      wr_reg(TXDATA_OFS, {23'h0, 1'b0, seed[7:0]});
      rd_reg(STATUS_OFS, 32'h1, 32'hf);
      repeat (84) @(posedge clk);
    end
    $display("test transmit done");
    // Receive back-to-back characters, keep the last
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      v = seed[15:8];
      host.send({1'b0, seed[7:0]}, 8, 1'b1);
      host.send({1'b0, v}, 8, 1'b1);
      rd_reg(RXDATA_OFS, {16'h1, 8'h0, v}, 32'h301ff);
    end
    host.glitch(2);
    repeat (30) @(posedge clk);
    rd_reg(RXDATA_OFS, 32'h0, 32'h30000);
    $display("test receive done");
    // Low stop bit gives a framing error and a break
    host.send(9'h055, 8, 1'b0);
    rd_reg(STATUS_OFS, 32'h4, 32'hf);
    n = 2;
    while (pin !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 4080 && n <= 4100, "break length");
    rd_reg(RXDATA_OFS, 32'h20000, 32'h20000);
    rd_reg(CTRL_OFS, 32'h4, 32'h4);
    wr_reg(CTRL_OFS, 32'h05);
    rd_reg(CTRL_OFS, 32'h1, 32'h5);
    // Nine-bit character lands with its top bit
    wr_reg(CTRL_OFS, 32'h09);
    seed = xs(seed);
    host.send(seed[8:0], 9, 1'b1);
    rd_reg(RXDATA_OFS, {15'h0, 1'b1, 7'h0, seed[8:0]}, 32'h301ff);
    $display("test framing done");
    // Disable hands the pin to the general port
    wr_reg(CTRL_OFS, 32'h00);
    repeat (2) @(posedge clk);
    chk(monitor_on === 1'b0, "monitor still on");
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      alt_out <= seed[0];
      alt_oe_n <= seed[1];
      repeat (2) @(posedge clk);
      chk(pin_out === seed[0] && pin_oe_n === seed[1], "pin not handed over");
    end
    $display("test disable done");
    // Lock keeps the monitor on
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    alt_oe_n <= 1'b1;
    @(posedge clk);
    chk(monitor_on === 1'b1, "monitor off after second reset");
    wr_reg(CTRL_OFS, 32'h03);
    wr_reg(CTRL_OFS, 32'h00);
    rd_reg(CTRL_OFS, 32'h3, 32'h3);
    repeat (2) @(posedge clk);
    chk(monitor_on === 1'b1, "locked monitor turned off");
    $display("test lock done");
    complete_run();
  end
endmodule // tb_top
